// ==== adc_mode_control_registers.sv ====
// mode control register bank of a four-channel converter, serial programming port
// assumes serial pins are asynchronous to clk and sck is far slower than clk
`timescale 1ns/1ps
`include "adc_mode_regs.svh"

// Functional notes
// [RQ1] reset bit clears registers, forces power-down
// [RQ2] reset bit clears itself when done
// [RQ3] bit 5 selects two's complement format
// [RQ4] low four bits: doze per channel
// [RQ5] any doze combination accepted at once
// [RQ6] sleep bit disables every channel
// [RQ7] bits 7-5 choose driver current
// [RQ8] termination bit doubles driver current
// [RQ9] bit 3 disables digital outputs
// [RQ10] bits 2-0 choose lanes and length
// [RQ11] pattern high bit 7 forces pattern
// [RQ12] pattern high bits give data 13-8
// [RQ13] pattern low gives data 7-0
// [RQ14] unused bits ignored on write
// [RQ15] scrambling enable, duty stabilizer disable bits
// [RQ16] host issues soft reset first
// [RQ17] frame: flag, seven address, eight data
// [RQ18] read returns data, changes nothing
// [RQ19] scrambling xors bits with lsb
// [RQ20] pattern overrides format and scrambling
module adc_mode_control_registers
  import adc_mode_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // serial programming pins
  input  wire logic        cs_n_pin,
  input  wire logic        sck_pin,
  input  wire logic        sdi_pin,
  output      logic        sdo_out,
  output      logic        sdo_oe,
  // converter samples in and formatted data out, channel 1 in the low bits
  input  wire logic [55:0] sample_in,
  output      logic [55:0] data_out,
  // format and power controls
  output      logic        duty_stabilizer_disable,
  output      logic        output_scramble_enable,
  output      logic        signed_format_select,
  output      logic [3:0]  channel_doze,
  output      logic        full_power_down,
  // output driver controls
  output      logic [2:0]  driver_current_select,
  output      logic [7:0]  drive_current_units,
  output      logic        internal_termination_enable,
  output      logic        driver_disable,
  output      logic [2:0]  lane_serialization_select,
  output      logic        two_lane_mode,
  output      logic [4:0]  serial_bit_count,
  // test pattern controls
  output      logic        pattern_force_enable,
  output      logic [5:0]  pattern_upper_bits,
  output      logic [7:0]  pattern_lower_bits
);
  localparam int SRST_MAX = `SRST_CYCLES;

  logic [2:0]     pins_level;
  logic           cs_n_s;
  logic           sck_s;
  logic           sdi_s;
  logic           sck_prev_reg;
  logic           sck_rise;
  logic           sck_fall;
  serial_state_t  state_reg;
  logic [4:0]     bit_cnt_reg;
  logic [14:0]    shift_reg;
  logic           rd_active_reg;
  logic [7:0]     rd_shift_reg;
  logic [7:0]     rd_value;
  logic           wr_stb;
  logic [6:0]     wr_addr;
  logic [7:0]     wr_data;
  logic           srst_stb;
  logic [7:0]     srst_cnt_reg;
  logic           srst_busy;
  logic [7:0]     format_power_ctrl_reg;
  logic [7:0]     output_drive_ctrl_reg;
  logic [7:0]     pattern_high_ctrl_reg;
  logic [7:0]     pattern_low_value_reg;
  sample_t        pattern;

  // speed of sck far below clk (six clk or more per sck phase)
  function automatic logic [6:0] base_current(input logic [2:0] code);
    unique case (code)
      3'h0: base_current = 7'h46;
      3'h1: base_current = 7'h50;
      3'h2: base_current = 7'h5a;
      3'h3: base_current = 7'h00;
      3'h4: base_current = 7'h3c;
      3'h5: base_current = 7'h32;
      3'h6: base_current = 7'h2a;
      3'h7: base_current = 7'h23;
    endcase
  endfunction : base_current

  function automatic sample_t format_sample(input sample_t raw, input logic signed_sel,
                                            input logic scramble, input logic force_pat,
                                            input sample_t pat);
    sample_t v;
    v = raw;
    if (signed_sel) begin
      v[13] = ~raw[13]; // RQ3
    end
    if (scramble) begin
      v[13:1] = v[13:1] ^ {13{v[0]}}; // RQ19
    end
    format_sample = force_pat ? pat : v;
  endfunction : format_sample

  // pin synchroniser
  pin_input_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h1)
  ) u_pin_sync (
    .clk       (clk),
    .reset     (reset),
    .pin_in    ({sdi_pin, sck_pin, cs_n_pin}),
    .level_out (pins_level)
  );

  assign cs_n_s   = pins_level[0];
  assign sck_s    = pins_level[1];
  assign sdi_s    = pins_level[2];
  assign sck_rise = sck_s & ~sck_prev_reg;
  assign sck_fall = ~sck_s & sck_prev_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_s;
    end
  end

  // serial frame receiver; edges after the sixteenth are ignored
  always_ff @(posedge clk) begin
    if (reset || cs_n_s) begin
      state_reg   <= S_IDLE;
      bit_cnt_reg <= 5'h00;
      shift_reg   <= 15'h0000;
    end else if (sck_rise) begin
      unique case (state_reg)
        S_IDLE, S_HEAD, S_DATA: begin
          shift_reg   <= {shift_reg[13:0], sdi_s}; // RQ17
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == `HEAD_BITS - 5'h01) begin
            state_reg <= S_DATA;
          end else if (bit_cnt_reg == `FRAME_BITS - 5'h01) begin
            state_reg <= S_DONE;
          end else if (state_reg == S_IDLE) begin
            state_reg <= S_HEAD;
          end
        end
        S_DONE: begin
          state_reg <= S_DONE;
        end
      endcase
    end
  end

  always_comb begin
    unique case ({1'b0, wr_addr})
      {1'b0, `ADDR_SOFT_RESET}:   rd_value = {srst_busy, 7'h00}; // RQ2
      {1'b0, `ADDR_FORMAT_POWER}: rd_value = format_power_ctrl_reg;
      {1'b0, `ADDR_OUTPUT_DRIVE}: rd_value = output_drive_ctrl_reg;
      {1'b0, `ADDR_PATTERN_HIGH}: rd_value = pattern_high_ctrl_reg;
      {1'b0, `ADDR_PATTERN_LOW}:  rd_value = pattern_low_value_reg;
      default:                    rd_value = 8'h00;
    endcase
  end

  // header ends at the eighth edge; address field sits in shift bits 5..0 plus sdi until then, in shift bits 13..7 after
  assign wr_addr  = (state_reg == S_DATA) ? shift_reg[13:7] : {shift_reg[5:0], sdi_s};
  assign wr_data  = {shift_reg[6:0], sdi_s};
  assign wr_stb   = sck_rise && state_reg == S_DATA && bit_cnt_reg == `FRAME_BITS - 5'h01
                    && !rd_active_reg; // RQ18
  assign srst_stb = wr_stb && wr_addr == `ADDR_SOFT_RESET && wr_data[`SRST_BIT]; // RQ14

  // read-back shifter; open-drain sdo pulls low for zero bits
  always_ff @(posedge clk) begin
    if (reset || cs_n_s) begin
      rd_active_reg <= 1'b0;
      rd_shift_reg  <= 8'hff;
    end else if (sck_rise && bit_cnt_reg == `HEAD_BITS - 5'h01) begin
      rd_active_reg <= shift_reg[6];
      rd_shift_reg  <= shift_reg[6] ? rd_value : 8'hff; // RQ18
    end else if (sck_fall && bit_cnt_reg > `HEAD_BITS && bit_cnt_reg < `FRAME_BITS) begin
      rd_shift_reg  <= {rd_shift_reg[6:0], 1'b1};
    end
  end

  assign sdo_out = 1'b0;

  always_ff @(posedge clk) begin
    if (reset) begin
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= rd_active_reg && !cs_n_s && !rd_shift_reg[7];
    end
  end

  // soft reset hold counter
  always_ff @(posedge clk) begin
    if (reset) begin
      srst_cnt_reg <= 8'h00;
    end else if (srst_stb) begin
      srst_cnt_reg <= 8'(SRST_MAX); // RQ1
    end else if (srst_busy) begin
      srst_cnt_reg <= srst_cnt_reg - 8'h01; // RQ2
    end
  end

  assign srst_busy = srst_cnt_reg != 8'h00;

  // register writes; ignored while a soft reset is in progress
  always_ff @(posedge clk) begin
    if (reset || srst_stb || srst_busy) begin
      format_power_ctrl_reg <= `REG_RESET_VAL; // RQ1
      output_drive_ctrl_reg <= `REG_RESET_VAL;
      pattern_high_ctrl_reg <= `REG_RESET_VAL;
      pattern_low_value_reg <= `REG_RESET_VAL;
    end else if (wr_stb) begin
      unique case ({1'b0, wr_addr})
        {1'b0, `ADDR_FORMAT_POWER}: format_power_ctrl_reg <= wr_data;
        {1'b0, `ADDR_OUTPUT_DRIVE}: output_drive_ctrl_reg <= wr_data;
        {1'b0, `ADDR_PATTERN_HIGH}: pattern_high_ctrl_reg <= wr_data & `PH_WRITE_MASK; // RQ14
        {1'b0, `ADDR_PATTERN_LOW}:  pattern_low_value_reg <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // control decode
  assign duty_stabilizer_disable     = format_power_ctrl_reg[`FP_DCS_OFF_BIT]; // RQ15
  assign output_scramble_enable      = format_power_ctrl_reg[`FP_SCRAMBLE_BIT]; // RQ15
  assign signed_format_select        = format_power_ctrl_reg[`FP_SIGNED_BIT]; // RQ3
  assign full_power_down             = format_power_ctrl_reg[`FP_SLEEP_BIT] | srst_busy; // RQ6
  assign channel_doze                = format_power_ctrl_reg[3:0] | {4{full_power_down}}; // RQ4 RQ5
  assign driver_current_select       = output_drive_ctrl_reg[`OD_CUR_MSB:`OD_CUR_LSB]; // RQ7
  assign internal_termination_enable = output_drive_ctrl_reg[`OD_TERM_BIT];
  assign drive_current_units         = internal_termination_enable
                                       ? {base_current(driver_current_select), 1'b0} // RQ8
                                       : {1'b0, base_current(driver_current_select)};
  assign driver_disable              = output_drive_ctrl_reg[`OD_DISABLE_BIT]; // RQ9
  assign lane_serialization_select   = output_drive_ctrl_reg[`OD_LANE_MSB:0];

  always_comb begin
    two_lane_mode = 1'b0;
    unique case (lane_serialization_select) // RQ10
      3'h0: begin serial_bit_count = 5'h10; two_lane_mode = 1'b1; end
      3'h1: begin serial_bit_count = 5'h0e; two_lane_mode = 1'b1; end
      3'h2: begin serial_bit_count = 5'h0c; two_lane_mode = 1'b1; end
      3'h5: serial_bit_count = 5'h0e;
      3'h6: serial_bit_count = 5'h0c;
      3'h7: serial_bit_count = 5'h10;
      default: serial_bit_count = 5'h00;
    endcase
  end

  assign pattern_force_enable = pattern_high_ctrl_reg[`PH_FORCE_BIT]; // RQ11
  assign pattern_upper_bits   = pattern_high_ctrl_reg[`PH_VALUE_MSB:0]; // RQ12
  assign pattern_lower_bits   = pattern_low_value_reg; // RQ13
  assign pattern              = {pattern_upper_bits, pattern_lower_bits};

  // sample formatting for all four channels
  always_ff @(posedge clk) begin
    if (reset) begin
      data_out <= 56'h0;
    end else begin
      for (int ch = 0; ch < 4; ch++) begin
        data_out[ch*14 +: 14] <= format_sample(sample_in[ch*14 +: 14], signed_format_select,
                                               output_scramble_enable, pattern_force_enable,
                                               pattern); // RQ20
      end
    end
  end

  // helper: length of the soft reset hold, checked when it ends
  logic [7:0] srst_len_reg;

  always_ff @(posedge clk) begin
    if (reset || srst_stb) begin
      srst_len_reg <= 8'h00;
    end else if (srst_busy) begin
      srst_len_reg <= srst_len_reg + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_srst_clears_bank: assert property (srst_stb |=> format_power_ctrl_reg == 8'h00 // RQ1
    && output_drive_ctrl_reg == 8'h00 && pattern_high_ctrl_reg == 8'h00 && full_power_down
    && pattern_low_value_reg == 8'h00)
    else $error("soft reset did not clear the bank");
  chk_srst_self_clear: assert property (srst_stb |=> srst_busy ##9 srst_busy ##1 !srst_busy) // RQ2
    else $error("soft reset bit did not clear on time");
  chk_srst_hold_len: assert property ($fell(srst_busy) |-> srst_len_reg == 8'(SRST_MAX)) // RQ2
    else $error("soft reset hold length wrong");
  chk_write_lands: assert property (wr_stb && !srst_busy && wr_addr == `ADDR_PATTERN_LOW // RQ17
    |=> pattern_low_value_reg == $past(wr_data))
    else $error("write did not reach the register");
  chk_sleep_all_off: assert property (format_power_ctrl_reg[4] |-> channel_doze == 4'hf) // RQ6
    else $error("sleep left a channel awake");
  chk_doze_per_chan: assert property (!full_power_down |-> // RQ4
    channel_doze == format_power_ctrl_reg[3:0])
    else $error("doze bits not followed");
  chk_read_no_write: assert property (rd_active_reg |=> $stable(format_power_ctrl_reg) // RQ18
    && $stable(output_drive_ctrl_reg) && $stable(pattern_high_ctrl_reg)
    && $stable(pattern_low_value_reg))
    else $error("read frame wrote a register");
  chk_pattern_wins: assert property (pattern_force_enable |=> // RQ20
    data_out[13:0] == $past(pattern) && data_out[55:42] == $past(pattern))
    else $error("test pattern not on every channel");
  chk_signed_msb: assert property (signed_format_select && !output_scramble_enable // RQ3
    && !pattern_force_enable |=> data_out[13] == !$past(sample_in[13]))
    else $error("two's complement msb wrong");
  chk_scramble_xor: assert property (output_scramble_enable && !signed_format_select // RQ19
    && !pattern_force_enable |=> (data_out[13:1] ^ {13{data_out[0]}}) == $past(sample_in[13:1]))
    else $error("scrambled data wrong");
  chk_unused_bit6: assert property (pattern_high_ctrl_reg[6] == 1'b0) // RQ14
    else $error("unused pattern bit stored");
  chk_term_double: assert property (internal_termination_enable && // RQ8
    driver_current_select == 3'h0 |-> drive_current_units == 8'h8c)
    else $error("termination did not double current");
  chk_frame_ignore: assert property (state_reg == S_DONE && sck_rise |=> // RQ17
    bit_cnt_reg == `FRAME_BITS)
    else $error("edge after sixteenth counted");

  cov_write_frame: cover property (wr_stb && wr_addr == `ADDR_OUTPUT_DRIVE);
  cov_read_frame: cover property (rd_active_reg && sdo_oe);
  cov_soft_reset: cover property (srst_stb ##1 srst_busy);
  cov_pattern_on: cover property (pattern_force_enable && !driver_disable);
  cov_full_sleep: cover property (format_power_ctrl_reg[`FP_SLEEP_BIT]);
endmodule : adc_mode_control_registers

// ==== adc_mode_control_registers_tb.sv ====
// self-checking bench for the mode control register bank
// assumes the host model and the design files are compiled before this file
`timescale 1ns/1ps
`include "adc_mode_regs.svh"
module adc_mode_control_registers_tb
  import adc_mode_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        cs_n_pin, sck_pin, sdi_pin, sdo_out, sdo_oe;
  wire  logic  sdo_line = sdo_oe ? sdo_out : 1'b1;
  logic [55:0] sample_in, data_out;
  logic        duty_stabilizer_disable, output_scramble_enable, signed_format_select;
  logic [3:0]  channel_doze;
  logic        full_power_down, internal_termination_enable, driver_disable, two_lane_mode;
  logic [2:0]  driver_current_select, lane_serialization_select;
  logic [7:0]  drive_current_units, pattern_lower_bits;
  logic [4:0]  serial_bit_count;
  logic        pattern_force_enable;
  logic [5:0]  pattern_upper_bits;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          pd_cnt = 0;
  int          p0;
  logic [7:0]  cur_tab [8] = '{8'h46, 8'h50, 8'h5a, 8'h00, 8'h3c, 8'h32, 8'h2a, 8'h23};
  logic [4:0]  bit_tab [8] = '{5'h10, 5'h0e, 5'h0c, 5'h00, 5'h00, 5'h0e, 5'h0c, 5'h10};

  always #2.5 clk = ~clk;

  always @(posedge clk) if (full_power_down === 1'b1) pd_cnt <= pd_cnt + 1;

  adc_mode_control_registers dut (
    .clk(clk), .reset(reset), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .sdi_pin(sdi_pin),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sample_in(sample_in), .data_out(data_out),
    .duty_stabilizer_disable(duty_stabilizer_disable),
    .output_scramble_enable(output_scramble_enable),
    .signed_format_select(signed_format_select), .channel_doze(channel_doze),
    .full_power_down(full_power_down), .driver_current_select(driver_current_select),
    .drive_current_units(drive_current_units),
    .internal_termination_enable(internal_termination_enable),
    .driver_disable(driver_disable), .lane_serialization_select(lane_serialization_select),
    .two_lane_mode(two_lane_mode), .serial_bit_count(serial_bit_count),
    .pattern_force_enable(pattern_force_enable), .pattern_upper_bits(pattern_upper_bits),
    .pattern_lower_bits(pattern_lower_bits)
  );

  host_serial_model host (
    .clk(clk), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .sdi_pin(sdi_pin), .sdo_line(sdo_line)
  );

  task automatic check(input logic [55:0] got, input logic [55:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n = 16);
    logic [7:0] unused;
    host.xfer(1'b0, a, d, n, 10, unused);
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] got;
    host.xfer(1'b1, a, 8'h5a, 16, 9, got);
    check({48'h0, got}, {48'h0, exp});
    check({55'h0, sdo_oe}, 56'h0);
  endtask : rd_chk

  // expected formatting of all four channels
  function automatic logic [55:0] fmt(input logic [55:0] s, input logic sg, input logic sc);
    sample_t     v;
    logic [55:0] r;
    for (int c = 0; c < 4; c++) begin
      v = s[c*14 +: 14];
      if (sg) v[13] = ~v[13];
      if (sc) v[13:1] = v[13:1] ^ {13{v[0]}};
      r[c*14 +: 14] = v;
    end
    return r;
  endfunction : fmt

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial begin
    sample_in = 56'h3a51f3c9876543;
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    repeat (5) @(posedge clk);
    for (int a = 0; a < 6; a++) rd_chk(a[6:0], 8'h00);
    check(data_out, fmt(sample_in, 1'b0, 1'b0));
    $display("test reset_values done");

    p0 = pd_cnt;
    wr(7'h00, 8'hff);
    check(56'(pd_cnt - p0), 56'(`SRST_CYCLES));
    rd_chk(7'h00, 8'h00);
    $display("test first_soft_reset done");

    wr(7'h01, 8'h40);
    wr(7'h02, 8'h5d);
    wr(7'h03, 8'hff);
    wr(7'h04, 8'h96);
    rd_chk(7'h03, 8'hbf);
    rd_chk(7'h02, 8'h5d);
    rd_chk(7'h01, 8'h40);
    wr(7'h04, 8'h11, 10);
    rd_chk(7'h04, 8'h96);
    wr(7'h04, 8'h3c, 20);
    rd_chk(7'h04, 8'h3c);
    wr(7'h05, 8'h77);
    rd_chk(7'h05, 8'h00);
    $display("test access done");

    p0 = pd_cnt;
    wr(7'h00, 8'h7f);
    check(56'(pd_cnt - p0), 56'h0);
    rd_chk(7'h01, 8'h40);
    p0 = pd_cnt;
    wr(7'h00, 8'h80);
    check(56'(pd_cnt - p0), 56'(`SRST_CYCLES));
    for (int a = 0; a < 5; a++) rd_chk(a[6:0], 8'h00);
    $display("test soft_reset done");

    for (int i = 0; i < 32; i++) begin
      wr(7'h01, {3'h0, i[4:0]});
      check({full_power_down, channel_doze}, {i[4], i[4] ? 4'hf : i[3:0]});
    end
    $display("test power_down done");

    wr(7'h01, 8'he0);
    check({duty_stabilizer_disable, output_scramble_enable, signed_format_select}, 3'h7);
    check(data_out, fmt(sample_in, 1'b1, 1'b1));
    @(posedge clk);
    #1 sample_in = 56'h05ae0c36789abc;
    @(posedge clk);
    #1 check(data_out, fmt(sample_in, 1'b1, 1'b1));
    wr(7'h01, 8'h20);
    check(data_out, fmt(sample_in, 1'b1, 1'b0));
    wr(7'h01, 8'h40);
    check(data_out, fmt(sample_in, 1'b0, 1'b1));
    $display("test format done");

    for (int c = 0; c < 8; c++) begin
      for (int t = 0; t < 2; t++) begin
        wr(7'h02, {c[2:0], t[0], c[0], c[2:0]});
        check({driver_current_select, drive_current_units, internal_termination_enable,
               driver_disable, lane_serialization_select, two_lane_mode, serial_bit_count},
              {c[2:0], cur_tab[c] << t, t[0], c[0], c[2:0], c < 3, bit_tab[c]});
      end
    end
    $display("test output_drive done");

    wr(7'h01, 8'h60);
    wr(7'h04, 8'hcd);
    wr(7'h03, 8'hab);
    check({pattern_force_enable, pattern_upper_bits, pattern_lower_bits}, 15'h6bcd);
    check(data_out, {4{6'h2b, 8'hcd}});
    wr(7'h03, 8'h2b);
    check(data_out, fmt(sample_in, 1'b1, 1'b1));
    $display("test pattern done");
    final_report();
  end
endmodule : adc_mode_control_registers_tb

// ==== adc_mode_pkg.sv ====
// types shared by the mode control register bank
// assumes the constants header is available on the include path
package adc_mode_pkg;
  `include "adc_mode_regs.svh"

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_HEAD = 2'b01,
    S_DATA = 2'b11,
    S_DONE = 2'b10
  } serial_state_t;

  typedef logic [13:0] sample_t;
endpackage : adc_mode_pkg

// ==== adc_mode_regs.svh ====
// constants for the mode control register bank: offsets, fields, resets, timing
// assumes inclusion by the package, the bank module and the bench only
`ifndef ADC_MODE_REGS_SVH
`define ADC_MODE_REGS_SVH

// register addresses on the serial port
`define ADDR_SOFT_RESET     7'h00
`define ADDR_FORMAT_POWER   7'h01
`define ADDR_OUTPUT_DRIVE   7'h02
`define ADDR_PATTERN_HIGH   7'h03
`define ADDR_PATTERN_LOW    7'h04

// field positions
`define SRST_BIT            7
`define FP_DCS_OFF_BIT      7
`define FP_SCRAMBLE_BIT     6
`define FP_SIGNED_BIT       5
`define FP_SLEEP_BIT        4
`define OD_CUR_MSB          7
`define OD_CUR_LSB          5
`define OD_TERM_BIT         4
`define OD_DISABLE_BIT      3
`define OD_LANE_MSB         2
`define PH_FORCE_BIT        7
`define PH_VALUE_MSB        5
`define PH_WRITE_MASK       8'hbf

// reset values
`define REG_RESET_VAL       8'h00

// serial frame
`define FRAME_BITS          5'h10
`define HEAD_BITS           5'h08

// soft reset power-down hold
`define CLK_PERIOD_NS       5
`define SRST_TIME_NS        50
`define SRST_CYCLES         ((`SRST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== host_serial_model.sv ====
// host controller model driving the serial programming port
// assumes sdo_line already carries the pull-up level when the device releases it
`timescale 1ns/1ps
module host_serial_model (
  // clock
  input  wire logic clk,
  // serial pins
  output      logic cs_n_pin,
  output      logic sck_pin,
  output      logic sdi_pin,
  input  wire logic sdo_line
);
  initial begin
    cs_n_pin = 1'b1;
    sck_pin  = 1'b0;
    sdi_pin  = 1'b0;
  end

  // one frame of n sck rises, half clocks per sck phase, readback sampled before rises 9..16
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] data,
                      input int n, input int half, output logic [7:0] rdata);
    logic [15:0] word;
    word = {rd, addr, data};
    rdata = 8'h00;
    @(posedge clk);
    #1 cs_n_pin = 1'b0;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      #1 sck_pin = 1'b0;
      sdi_pin = word[15 - (k % 16)];
      repeat (half) @(posedge clk);
      #1;
      if (k >= 8 && k < 16) rdata[15 - k] = sdo_line;
      sck_pin = 1'b1;
      repeat (half) @(posedge clk);
    end
    #1 sck_pin = 1'b0;
    repeat (half) @(posedge clk);
    #1 cs_n_pin = 1'b1;
    sdi_pin = ~sdi_pin;
    repeat (half) @(posedge clk);
  endtask : xfer
endmodule : host_serial_model

// ==== pin_input_sync.sv ====
// three-flop pin synchroniser with agreement filter
// assumes inputs are asynchronous pins; output changes once stages two and three agree
`timescale 1ns/1ps
module pin_input_sync #(
  parameter int           WIDTH     = 3,
  parameter logic [2:0]   RESET_VAL = 3'h1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_in,
  output      logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      stage1_reg <= RESET_VAL[WIDTH-1:0];
      stage2_reg <= RESET_VAL[WIDTH-1:0];
      stage3_reg <= RESET_VAL[WIDTH-1:0];
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      level_out <= RESET_VAL[WIDTH-1:0];
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          level_out[i] <= stage3_reg[i];
        end
      end
    end
  end
endmodule : pin_input_sync
